/* File: tas_pkg.sv */
`default_nettype none
package tas_pkg;
  // register map
  localparam logic [7:0]  TAS_ALERT_ADDR  = 8'h02;
  localparam logic [15:0] TAS_ALERT_RESET = 16'h0000;
  // bit positions in the alert status word
  localparam int TAS_BIT_CHK_FAIL   = 7;
  localparam int TAS_BIT_RISE_STATE = 6;
  localparam int TAS_BIT_RISE_FLAG  = 5;
  localparam int TAS_BIT_UPPER_ST   = 4;
  localparam int TAS_BIT_LOWER_ST   = 3;
  localparam int TAS_BIT_UPPER_FLAG = 2;
  localparam int TAS_BIT_LOWER_FLAG = 1;
  localparam int TAS_BIT_NEW_DATA   = 0;
  // threshold words carry a 14-bit value in bits 15:2
  localparam int TAS_LIM_LSB = 2;
  localparam logic [1:0] TAS_LIM_PAD = 2'h0;

  // one completed conversion
  typedef struct packed {
    logic        valid;
    logic [15:0] temp;
    logic [15:0] slew;
  } tas_conv_t;

  // current limit settings, all in register word format
  typedef struct packed {
    logic [15:0] upper_threshold;
    logic [15:0] lower_threshold;
    logic [15:0] upper_hysteresis;
    logic [15:0] lower_hysteresis;
    logic [15:0] slew_threshold;
  } tas_limits_t;

  // outcome of a checksum protected write
  typedef struct packed {
    logic done;
    logic fail;
  } tas_chk_t;
endpackage
`default_nettype wire

/* File: tas_alert.sv */
`default_nettype none
module tas_alert
  import tas_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // register access from the serial engine
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // conversion results and limits
  input  wire tas_conv_t   conv,
  input  wire tas_limits_t limits,
  // checksum control
  input  wire logic        chk_enable,
  input  wire logic        bus_stop,
  input  wire tas_chk_t    chk,
  output logic             write_discard,
  // live status word
  output logic      [15:0] alert_state
);

  // where the reserved upper byte starts, and how many flags are sticky
  localparam int TAS_RSV_LSB  = 8;
  localparam int TAS_N_STICKY = 5;
  // sign bits added when a 16-bit word is widened to 18 bits
  localparam int TAS_EXT_W    = 2;
  // flag positions, in the order of the set vector further down
  localparam int TAS_STICKY_POS [TAS_N_STICKY] = '{TAS_BIT_NEW_DATA, TAS_BIT_LOWER_FLAG, TAS_BIT_UPPER_FLAG,
                                                   TAS_BIT_RISE_FLAG, TAS_BIT_CHK_FAIL};

  // status register and the word it loads next
  logic [15:0]             alert_state_r;
  logic [15:0]             alert_state_nxt;
  // checksum arming, crossing re-arm and slew history
  logic                    chk_armed_r;
  logic                    upper_armed_r;
  logic                    lower_armed_r;
  logic                    rise_prev_r;
  // registered outputs towards the serial engine
  logic [15:0]             reg_rdata_r;
  logic                    discard_r;
  // next values of the sticky flags, one per entry of the position table
  logic [TAS_N_STICKY-1:0] sticky_nxt;

  // sign extension of the result and limit words
  wire logic [1:0]         temp_sx  = {TAS_EXT_W{conv.temp[15]}};
  wire logic [1:0]         up_sx    = {TAS_EXT_W{limits.upper_threshold[15]}};
  wire logic [1:0]         lo_sx    = {TAS_EXT_W{limits.lower_threshold[15]}};
  // hysteresis is unsigned, so it is widened with zeros
  wire logic [1:0]         hys_pad  = 2'h0;

  // limits on the result scale: one limit step is four result steps, so the
  // 14-bit value keeps its place in the word and only gains sign bits on top;
  // shifting it further would make every limit four times too large
  wire logic signed [17:0] up_thr   = {up_sx, limits.upper_threshold[15:TAS_LIM_LSB], TAS_LIM_PAD};
  wire logic signed [17:0] lo_thr   = {lo_sx, limits.lower_threshold[15:TAS_LIM_LSB], TAS_LIM_PAD};
  wire logic signed [17:0] up_hys   = {hys_pad, limits.upper_hysteresis[15:TAS_LIM_LSB], TAS_LIM_PAD};
  wire logic signed [17:0] lo_hys   = {hys_pad, limits.lower_hysteresis[15:TAS_LIM_LSB], TAS_LIM_PAD};
  wire logic signed [17:0] temp_w   = {temp_sx, conv.temp};

  // release points; 18 bits leave room for a wide hysteresis without wrap
  wire logic signed [17:0] up_rel   = up_thr - up_hys;
  wire logic signed [17:0] lo_rel   = lo_thr + lo_hys;

  // limit compares, all off while the limits are inverted or equal
  wire logic               lim_ok   = up_thr > lo_thr;
  wire logic               above_up = lim_ok && (temp_w > up_thr);
  wire logic               below_ur = lim_ok && (temp_w < up_rel);
  wire logic               below_lo = lim_ok && (temp_w < lo_thr);
  wire logic               above_lr = lim_ok && (temp_w > lo_rel);

  // slew compare: only non-negative rates count, a falling temperature never trips it
  wire logic signed [13:0] slew_v   = conv.slew[15:TAS_LIM_LSB];
  wire logic signed [13:0] slew_thr = limits.slew_threshold[15:TAS_LIM_LSB];
  wire logic               slew_pos = !slew_v[13];
  wire logic               rise_now = slew_pos && (slew_v > slew_thr);

  // event terms; all but the checksum term move only when a conversion completes
  wire logic ev        = conv.valid;
  wire logic up_set_ev = ev && above_up && upper_armed_r;
  wire logic up_clr_ev = ev && below_ur && alert_state_r[TAS_BIT_UPPER_ST];
  wire logic lo_set_ev = ev && below_lo && lower_armed_r;
  wire logic lo_clr_ev = ev && above_lr && alert_state_r[TAS_BIT_LOWER_ST];
  wire logic rise_ev   = ev && (rise_now != rise_prev_r);
  // a failing write counts only once a stop has armed the checking
  wire logic chk_ev    = chk.done && chk.fail && chk_armed_r;

  // register decode: a read of the status address is the only clear
  wire logic addr_hit  = (reg_addr == TAS_ALERT_ADDR);
  wire logic rd_clr    = reg_rd && addr_hit;

  // set vector of the sticky flags, ordered as the position table
  wire logic [TAS_N_STICKY-1:0] sticky_set = {chk_ev, rise_ev, up_set_ev | up_clr_ev, lo_set_ev | lo_clr_ev, ev};

  // sticky flags: a read clears, a set in the same cycle wins so that an
  // event landing on the read edge is reported by the next read
  for (genvar gi = 0; gi < TAS_N_STICKY; gi++) begin : g_sticky
    assign sticky_nxt[gi] = sticky_set[gi] | (alert_state_r[TAS_STICKY_POS[gi]] & ~rd_clr);
  end

  // live bits, reloaded only when a conversion completes
  wire logic upper_st_hold = alert_state_r[TAS_BIT_UPPER_ST];
  wire logic lower_st_hold = alert_state_r[TAS_BIT_LOWER_ST];
  // between the limit and its release point the bit keeps its value
  wire logic upper_st_new  = above_up ? 1'b1 : ((below_ur || !lim_ok) ? 1'b0 : upper_st_hold);
  wire logic lower_st_new  = below_lo ? 1'b1 : ((above_lr || !lim_ok) ? 1'b0 : lower_st_hold);
  wire logic upper_st_nxt  = ev ? upper_st_new : upper_st_hold;
  wire logic lower_st_nxt  = ev ? lower_st_new : lower_st_hold;
  wire logic rise_st_nxt   = ev ? rise_now : alert_state_r[TAS_BIT_RISE_STATE];

  // re-arm points of the crossing flags: a set disarms, the release point re-arms
  wire logic upper_arm_nxt = up_set_ev ? 1'b0 : (below_ur ? 1'b1 : upper_armed_r);
  wire logic lower_arm_nxt = lo_set_ev ? 1'b0 : (above_lr ? 1'b1 : lower_armed_r);

  // read data holds until the next status read; other addresses leave it alone
  wire logic [15:0] rdata_nxt = rd_clr ? alert_state_r : reg_rdata_r;

  // next status word: reserved byte, sticky flags, live bits
  always_comb begin
    alert_state_nxt = alert_state_r;
    alert_state_nxt[15:TAS_RSV_LSB] = TAS_ALERT_RESET[15:TAS_RSV_LSB];
    for (int i = 0; i < TAS_N_STICKY; i++) begin
      alert_state_nxt[TAS_STICKY_POS[i]] = sticky_nxt[i];
    end
    alert_state_nxt[TAS_BIT_RISE_STATE] = rise_st_nxt;
    alert_state_nxt[TAS_BIT_UPPER_ST]   = upper_st_nxt;
    alert_state_nxt[TAS_BIT_LOWER_ST]   = lower_st_nxt;
  end

  // status register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      alert_state_r <= TAS_ALERT_RESET;
    end else begin
      alert_state_r <= alert_state_nxt;
    end
  end

  // re-arm tracking for the crossing flags and slew history
  // both crossing flags start armed so the first crossing after reset counts
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      upper_armed_r <= 1'b1;
      lower_armed_r <= 1'b1;
      rise_prev_r   <= 1'b0;
    end else if (ev) begin
      upper_armed_r <= upper_arm_nxt;
      lower_armed_r <= lower_arm_nxt;
      rise_prev_r   <= rise_now;
    end
  end

  // checksum enable arms only at the stop that follows it
  // a change of the enable in mid transaction therefore has no effect yet
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      chk_armed_r <= 1'b0;
    end else if (bus_stop) begin
      chk_armed_r <= chk_enable;
    end
  end

  // read data register, loaded with the word as it stood before the clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_r <= TAS_ALERT_RESET;
    end else begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  // discard strobe, one cycle for each counted failing write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      discard_r <= 1'b0;
    end else begin
      discard_r <= chk_ev;
    end
  end

  // outputs straight from their flip-flops
  assign reg_rdata     = reg_rdata_r;
  assign write_discard = discard_r;
  assign alert_state   = alert_state_r;

endmodule
`default_nettype wire

/* File: tas_alert_props.sv */
`default_nettype none
module tas_alert_props
  import tas_pkg::*;
(
  // clock, reset and register access
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // conversions, limits and checksum
  input wire tas_conv_t   conv,
  input wire tas_limits_t limits,
  input wire logic        chk_enable,
  input wire logic        bus_stop,
  input wire tas_chk_t    chk,
  input wire logic        write_discard,
  input wire logic [15:0] alert_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // status read with no competing set in the same cycle
  sequence s_rd;
    reg_rd && reg_addr == TAS_ALERT_ADDR && !conv.valid && !chk.done;
  endsequence
  // rise and upper compares as the rules give them
  wire logic rise_now = !conv.slew[15] && $signed(conv.slew) > $signed(limits.slew_threshold);
  wire logic hot_now = $signed(conv.temp) > $signed(limits.upper_threshold)
                       && $signed(limits.upper_threshold) > $signed(limits.lower_threshold);
  chk_upper_byte: assert property (alert_state[15:8] == 8'h00)
    else $error("upper byte not zero");
  chk_read_word: assert property (s_rd |=> reg_rdata == $past(alert_state))
    else $error("read word wrong");
  chk_read_clear: assert property (s_rd |=> (alert_state & 16'h00A7) == 16'h0000)
    else $error("sticky bits kept");
  chk_live_kept: assert property (s_rd |=> (alert_state & 16'h0058) == ($past(alert_state) & 16'h0058))
    else $error("live bits lost");
  chk_rise_state: assert property (conv.valid |=> alert_state[6] == $past(rise_now))
    else $error("rise state wrong");
  chk_upper_set: assert property (conv.valid && hot_now |=> alert_state[4])
    else $error("upper state not set");
  chk_new_data: assert property (conv.valid |=> alert_state[0])
    else $error("new data not set");
  chk_discard: assert property (write_discard |-> alert_state[7] ##1 !write_discard)
    else $error("discard pulse wrong");
endmodule
bind tas_alert tas_alert_props i_props (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .conv(conv), .limits(limits), .chk_enable(chk_enable), .bus_stop(bus_stop), .chk(chk),
  .write_discard(write_discard), .alert_state(alert_state));
`default_nettype wire

/* File: tas_host.sv */
`default_nettype none
module tas_host (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // bench requests and register side
  input  wire logic       go,
  input  wire logic [7:0] addr_in,
  output logic            reg_rd,
  output logic      [7:0] reg_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // one-cycle read strobe; a released address flips to its inverse on every cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rd <= 1'b0;
      reg_addr <= 8'h00;
    end else begin
      reg_rd <= go;
      reg_addr <= go ? addr_in : ~reg_addr;
    end
  end
endmodule
`default_nettype wire

/* File: tas_alert_tb.sv */
`default_nettype none
module tas_alert_tb;
  import tas_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, nrst, go, chk_enable, bus_stop, reg_rd, write_discard;
  logic [7:0]  addr_in, reg_addr;
  logic [15:0] reg_rdata, alert_state;
  tas_conv_t   conv;
  tas_limits_t limits;
  tas_chk_t    chk;
  int          failures, n_checks;
  // temperature, slew and expected status per conversion
  logic [15:0] t_tab [8] = '{16'h0D00, 16'h0C00, 16'h0D00, 16'h0A00, 16'hFF00, 16'h0080, 16'h0300, 16'hFF00};
  logic [15:0] s_tab [8] = '{16'h0200, 16'h0200, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] e_tab [8] = '{16'h0075, 16'h0051, 16'h0031, 16'h0005, 16'h000B, 16'h0009, 16'h0003, 16'h000B};
  tas_host i_host (.sys_clk(sys_clk), .nrst(nrst), .go(go), .addr_in(addr_in), .reg_rd(reg_rd), .reg_addr(reg_addr));
  tas_alert i_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv(conv), .limits(limits), .chk_enable(chk_enable), .bus_stop(bus_stop), .chk(chk),
    .write_discard(write_discard), .alert_state(alert_state));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one conversion, then the status word one cycle later
  task automatic cv(logic [15:0] t, logic [15:0] s, logic [15:0] e);
    @(posedge sys_clk);
    conv <= '{1'b1, t, s};
    @(posedge sys_clk);
    conv.valid <= 1'b0;
    #1 check("status", alert_state, e);
  endtask
  // host read through the partner, data and post-read word checked
  task automatic rd(logic [7:0] a, logic [15:0] d, logic [15:0] e);
    @(posedge sys_clk);
    go <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    #1 check("read data", reg_rdata, d);
    check("after read", alert_state, e);
  endtask
  task automatic sc_conversions;
    for (int i = 0; i < 8; i++) begin
      cv(t_tab[i], s_tab[i], e_tab[i]);
      rd(TAS_ALERT_ADDR, e_tab[i], e_tab[i] & 16'h0058);
    end
  endtask
  // upper equal to lower makes both limits inert
  task automatic sc_ignored;
    limits.upper_threshold <= 16'h0000;
    cv(16'hFF00, 16'h0000, 16'h0001);
    rd(TAS_ALERT_ADDR, 16'h0001, 16'h0000);
  endtask
  task automatic crc(logic en, logic [15:0] e);
    @(posedge sys_clk);
    chk_enable <= en;
    bus_stop <= 1'b1;
    @(posedge sys_clk);
    bus_stop <= 1'b0;
    chk <= 2'b11;
    @(posedge sys_clk);
    chk <= 2'b00;
    #1 check("discard", {15'h0000, write_discard}, {15'h0000, e[7]});
    check("chk flag", alert_state, e);
  endtask
  // unarmed failure ignored, armed one flagged, unmapped read leaves all alone
  task automatic sc_checksum;
    crc(1'b0, 16'h0000);
    crc(1'b1, 16'h0080);
    rd(8'h03, 16'h0001, 16'h0080);
    rd(TAS_ALERT_ADDR, 16'h0080, 16'h0000);
  endtask
  initial begin
    failures = 0;
    n_checks = 0;
    nrst = 1'b0;
    go = 1'b0;
    addr_in = 8'h00;
    conv = '0;
    limits = '{16'h0C80, 16'h0000, 16'h0100, 16'h0100, 16'h0100};
    chk = '0;
    chk_enable = 1'b0;
    bus_stop = 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    #1 check("reset", alert_state, TAS_ALERT_RESET);
    sc_conversions();
    sc_ignored();
    sc_checksum();
    close_out();
  end
endmodule
`default_nettype wire
